// ### pkg/tcp_pkg.sv
/*
 * Constants for the triple counter pacer: port offsets, control byte
 * fields, mode codes and the internal pacer clock timing.
 * Assumes a single 100 MHz clock and byte wide host port accesses.
 */
package tcp_pkg;
	// ==================================================================
	// Port offsets
	localparam logic [1:0] OFS_CNT0 = 2'h0;
	localparam logic [1:0] OFS_CNT1 = 2'h1;
	localparam logic [1:0] OFS_CNT2 = 2'h2;
	localparam logic [1:0] OFS_CTRL = 2'h3;

	// ==================================================================
	// Control byte fields
	localparam int SEL_POS  = 6;
	localparam int ACC_POS  = 4;
	localparam int MODE_POS = 1;
	localparam int BCD_POS  = 0;
	localparam logic [1:0] SEL_ILLEGAL = 2'h3;

	// Access types
	localparam logic [1:0] ACC_LATCH = 2'h0;
	localparam logic [1:0] ACC_LOW   = 2'h1;
	localparam logic [1:0] ACC_HIGH  = 2'h2;
	localparam logic [1:0] ACC_BOTH  = 2'h3;

	// Normalised mode codes
	localparam logic [2:0] MODE_TC     = 3'h0;
	localparam logic [2:0] MODE_ONESHOT = 3'h1;
	localparam logic [2:0] MODE_RATE   = 3'h2;
	localparam logic [2:0] MODE_SQUARE = 3'h3;
	localparam logic [2:0] MODE_SWSTB  = 3'h4;
	localparam logic [2:0] MODE_HWSTB  = 3'h5;

	// ==================================================================
	// Reset values and timing
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic        OUT_RESET = 1'b1;
	localparam int MCLK_KHZ   = 100000;
	localparam int PACER_KHZ  = 2000;
	localparam int PACER_DIV  = MCLK_KHZ / PACER_KHZ;
	localparam int MAX_CLK_KHZ = 5000;
endpackage

// ### rtl/tcp_dec.sv
/*
 * Down step of a counter value by one or two, in binary or four-digit
 * decimal format. Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module tcp_dec (
	input  wire logic [15:0] val_i,   // Present count
	input  wire logic        bcd_i,   // Decimal format
	input  wire logic        two_i,   // Step by two
	output logic      [15:0] res_o    // Decremented count
);
	// ==================================================================
	// Digit-wise borrow chain; zero stepped by one wraps to 9999 or FFFF, by two to 9998 or FFFE
	always_comb begin
		logic [4:0] t;
		logic [4:0] sub;
		t   = 5'h00;
		sub = two_i ? 5'h02 : 5'h01;
		res_o = val_i - {14'h0000, sub[1:0]};
		if (bcd_i) begin
			for (int i = 0; i < 4; i++) begin
				t = {1'b0, val_i[4*i +: 4]} - sub;
				if (t[4]) begin
					res_o[4*i +: 4] = 4'((t + 5'h0A));
					sub = 5'h01;
				end else begin
					res_o[4*i +: 4] = t[3:0];
					sub = 5'h00;
				end
			end
		end
	end
endmodule

// ### rtl/tcp_top.sv
/*
 * Triple counter pacer: three 16-bit down counters behind a byte-wide
 * host port of four offsets. Counter 0 is a general timer, counters 1
 * and 2 form the conversion pacer from an internal 2 MHz tick.
 * Assumes all inputs are synchronous to mclk_i.
 */
`timescale 1ns/1ps
module tcp_top (
	input  wire logic       mclk_i,         // 100 MHz clock
	input  wire logic       rst_i,          // Sync reset, active high
	input  wire logic [1:0] addr_i,         // Port offset
	input  wire logic [7:0] wdata_i,        // Write byte
	input  wire logic       wr_i,           // Write strobe
	input  wire logic       rd_i,           // Read strobe
	output logic      [7:0] rdata_o,        // Read byte, next cycle
	input  wire logic       clk0_ext_i,     // Counter 0 external clock
	input  wire logic       clk0_src_ext_i, // Counter 0 uses external clk
	input  wire logic [2:0] gate_i,         // Counter gates
	output logic      [2:0] out_o,          // Counter outputs
	output logic            pacer_trig_o    // Conversion start pulse
);
	// ==================================================================
	// Elaboration check: tick must be slower than the clock
	// The prescaler is 8 bits wide, so the divider must fit in it
	if (tcp_pkg::PACER_DIV < 2 || tcp_pkg::PACER_DIV > 256 ||
	    tcp_pkg::MAX_CLK_KHZ * 2 > tcp_pkg::MCLK_KHZ) begin : g_chk
		$error("tcp_top: clock unsuited to counter inputs");
	end

	// ==================================================================
	// Internal 2 MHz tick and edge history
	logic [7:0] pre_cnt;
	logic [7:0] next_pre_cnt;
	logic       ext_prev;
	logic [2:0] out_prev;
	logic       trig;
	logic [7:0] rdata;
	logic [2:0] tick;
	logic [2:0][7:0] rd_byte;
	logic       src_tick;
	logic [7:0] next_rdata;
	logic       next_trig;

	// Prescaler and cascade: counter 1 output clocks counter 2
	always_comb begin
		src_tick = (pre_cnt == 8'(tcp_pkg::PACER_DIV - 1));
		next_pre_cnt = src_tick ? 8'h00 : pre_cnt + 8'h01;
		tick[0] = clk0_src_ext_i ? (clk0_ext_i & ~ext_prev)
		                         : src_tick;
		tick[1] = src_tick;
		tick[2] = out_o[1] & ~out_prev[1];
		next_trig = out_prev[2] & ~out_o[2];
		next_rdata = rdata;
		if (rd_i) begin
			next_rdata = (addr_i == tcp_pkg::OFS_CTRL) ? 8'h00
			                                           : rd_byte[addr_i];
		end
	end

	// Edges at 100 MHz resolve any input clock up to 5 MHz
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pre_cnt  <= 8'h00;
			ext_prev <= 1'b0;
			out_prev <= 3'h7;
			trig     <= 1'b0;
			rdata    <= 8'h00;
		end else begin
			pre_cnt  <= next_pre_cnt;
			ext_prev <= clk0_ext_i;
			out_prev <= out_o;
			trig     <= next_trig;
			rdata    <= next_rdata;
		end
	end

	assign pacer_trig_o = trig;
	assign rdata_o      = rdata;

	// ==================================================================
	// Control byte decode, shared by all counters
	logic       ctl_wr;
	logic [1:0] ctl_sel;
	logic [1:0] ctl_acc;
	logic [2:0] ctl_mode;
	always_comb begin
		ctl_sel  = wdata_i[tcp_pkg::SEL_POS +: 2];
		ctl_acc  = wdata_i[tcp_pkg::ACC_POS +: 2];
		ctl_mode = wdata_i[tcp_pkg::MODE_POS +: 3];
		if (ctl_mode[1])
			ctl_mode[2] = 1'b0;
		// Illegal select is dropped so no counter is disturbed
		ctl_wr = wr_i && addr_i == tcp_pkg::OFS_CTRL
		         && ctl_sel != tcp_pkg::SEL_ILLEGAL;
	end

	// ==================================================================
	// Counters, one per generate pass
	for (genvar g = 0; g < 3; g++) begin : g_cnt
		logic [15:0] cnt, cr, lat, dec;
		logic [2:0]  mode;
		logic [1:0]  acc;
		logic        bcd, latched, rptr, wptr, pend, armed, run;
		logic        out, gprev;
		logic [15:0] next_cnt, next_cr, next_lat;
		logic [2:0]  next_mode;
		logic [1:0]  next_acc;
		logic        next_bcd, next_latched, next_rptr, next_wptr;
		logic        next_pend, next_armed, next_run, next_out;
		logic        sel, dwr, drd, loaded;

		tcp_dec u_dec (
			.val_i (cnt),
			.bcd_i (bcd),
			.two_i (mode == tcp_pkg::MODE_SQUARE),
			.res_o (dec)
		);

		// Read byte: latched snapshot first, else live count
		always_comb begin
			logic [15:0] src;
			src = latched ? lat : cnt;
			rd_byte[g] = (acc == tcp_pkg::ACC_HIGH ||
			              (acc == tcp_pkg::ACC_BOTH && rptr))
			             ? src[15:8] : src[7:0];
		end

		// Next state of one counter
		always_comb begin
			sel  = ctl_wr && ctl_sel == 2'(g);
			dwr  = wr_i && addr_i == 2'(g);
			drd  = rd_i && addr_i == 2'(g);
			next_cnt = cnt;   next_cr = cr;     next_lat = lat;
			next_mode = mode; next_acc = acc;   next_bcd = bcd;
			next_latched = latched; next_rptr = rptr;
			next_wptr = wptr; next_pend = pend; next_armed = armed;
			next_run = run;   next_out = out;   loaded = 1'b0;

			// Gate rising edge triggers modes 1, 2, 3 and 5
			if (gate_i[g] && !gprev && mode != tcp_pkg::MODE_TC
			    && mode != tcp_pkg::MODE_SWSTB)
				next_armed = 1'b1;

			if (tick[g]) begin
				if (pend || armed) begin
					next_cnt = (mode == tcp_pkg::MODE_SQUARE)
					           ? {cr[15:1], 1'b0} : cr;
					next_pend = 1'b0;
					next_armed = 1'b0;
					next_run = 1'b1;
					if (mode == tcp_pkg::MODE_ONESHOT)
						next_out = 1'b0;
				end else if (run && (gate_i[g] ||
				             mode == tcp_pkg::MODE_ONESHOT ||
				             mode == tcp_pkg::MODE_HWSTB)) begin
					next_cnt = dec;
					unique case (mode)
						tcp_pkg::MODE_TC,
						tcp_pkg::MODE_ONESHOT: begin
							if (cnt == 16'h0001)
								next_out = 1'b1;
						end
						tcp_pkg::MODE_RATE: begin
							if (cnt == 16'h0001) begin
								next_cnt = cr;
								next_out = 1'b1;
							end else begin
								next_out = (cnt != 16'h0002);
							end
						end
						tcp_pkg::MODE_SQUARE: begin
							// Odd counts are trimmed to even halves
							if (cnt == 16'h0002) begin
								next_cnt = {cr[15:1], 1'b0};
								next_out = ~out;
							end
						end
						default: next_out = (cnt != 16'h0001);
					endcase
				end
			end
			// Rate and square outputs park high while the gate is low
			if (!gate_i[g] && (mode == tcp_pkg::MODE_RATE ||
			                   mode == tcp_pkg::MODE_SQUARE))
				next_out = 1'b1;

			if (drd) begin
				if (acc == tcp_pkg::ACC_BOTH)
					next_rptr = ~rptr;
				if (acc != tcp_pkg::ACC_BOTH || rptr)
					next_latched = 1'b0;
			end

			if (dwr) begin
				unique case (acc)
					tcp_pkg::ACC_LOW: begin
						next_cr = {8'h00, wdata_i};
						loaded = 1'b1;
					end
					tcp_pkg::ACC_HIGH: begin
						next_cr = {wdata_i, 8'h00};
						loaded = 1'b1;
					end
					tcp_pkg::ACC_BOTH: begin
						if (!wptr)
							next_cr[7:0] = wdata_i;
						else
							next_cr[15:8] = wdata_i;
						next_wptr = ~wptr;
						loaded = wptr;
					end
					default: ;
				endcase
				if (loaded && mode != tcp_pkg::MODE_ONESHOT &&
				    mode != tcp_pkg::MODE_HWSTB)
					next_pend = 1'b1;
				if (mode == tcp_pkg::MODE_TC) begin
					next_out = 1'b0;
					next_run = next_run & ~(acc == tcp_pkg::ACC_BOTH
					                        && !wptr);
				end
			end

			if (sel) begin
				if (ctl_acc == tcp_pkg::ACC_LATCH) begin
					if (!latched) begin
						next_lat = cnt;
						next_latched = 1'b1;
					end
				end else begin
					next_mode = ctl_mode;
					next_acc  = ctl_acc;
					next_bcd  = wdata_i[tcp_pkg::BCD_POS];
					next_out  = (ctl_mode != tcp_pkg::MODE_TC);
					next_rptr = 1'b0;
					next_wptr = 1'b0;
					next_pend = 1'b0;
					next_armed = 1'b0;
					next_run  = 1'b0;
					next_latched = 1'b0;
				end
			end
		end

		// Counter state registers
		always_ff @(posedge mclk_i) begin
			if (rst_i) begin
				cnt <= tcp_pkg::CNT_RESET;
				cr  <= tcp_pkg::CNT_RESET;
				lat <= tcp_pkg::CNT_RESET;
				mode <= tcp_pkg::MODE_TC;
				acc  <= tcp_pkg::ACC_LOW;
				bcd  <= 1'b0;
				latched <= 1'b0;
				rptr <= 1'b0;
				wptr <= 1'b0;
				pend <= 1'b0;
				armed <= 1'b0;
				run  <= 1'b0;
				out  <= tcp_pkg::OUT_RESET;
				gprev <= 1'b0;
			end else begin
				cnt <= next_cnt;
				cr  <= next_cr;
				lat <= next_lat;
				mode <= next_mode;
				acc  <= next_acc;
				bcd  <= next_bcd;
				latched <= next_latched;
				rptr <= next_rptr;
				wptr <= next_wptr;
				pend <= next_pend;
				armed <= next_armed;
				run  <= next_run;
				out  <= next_out;
				gprev <= gate_i[g];
			end
		end

		assign out_o[g] = out;
	end
endmodule

// ### testbench/tcp_monitor.sv
/* Port checker for the triple counter pacer.
   Bound to tcp_top; sees only its ports, one clock domain. */
`timescale 1ns/1ps
module tcp_monitor (
	input wire logic       mclk_i,         // Clock
	input wire logic       rst_i,          // Sync reset
	input wire logic [1:0] addr_i,         // Port offset
	input wire logic [7:0] wdata_i,        // Write byte
	input wire logic       wr_i,           // Write strobe
	input wire logic       rd_i,           // Read strobe
	input wire logic [7:0] rdata_o,        // Read byte
	input wire logic       clk0_ext_i,     // Counter 0 ext clock
	input wire logic       clk0_src_ext_i, // Counter 0 ext source
	input wire logic [2:0] gate_i,         // Gates
	input wire logic [2:0] out_o,          // Counter outputs
	input wire logic       pacer_trig_o    // Conversion trigger
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// ==================================================================
	// Helpers
	logic [15:0] gap;
	logic [15:0] next_gap;
	logic        ctl_wr;
	assign ctl_wr = wr_i && addr_i == 2'h3;
	// Cycles since last trigger; saturates so a long idle never wraps
	always_comb begin
		next_gap = (gap == 16'hFFFF) ? gap : gap + 16'h0001;
		if (rst_i) next_gap = 16'hFFFF;
		else if (pacer_trig_o) next_gap = 16'h0000;
	end
	always_ff @(posedge mclk_i) begin
		gap <= next_gap;
	end
	sequence s_out2_fall;
		out_o[2] ##1 !out_o[2];
	endsequence
	sequence s_ctl0;
		ctl_wr && wdata_i[7:6] == 2'h0 && wdata_i[5:4] != 2'h0;
	endsequence
	// ==================================================================
	// Properties
	a_trig_after_fall: assert property (s_out2_fall |=> pacer_trig_o)
		else $error("no trigger after pacer output fell");
	a_trig_needs_fall: assert property (pacer_trig_o |->
		$past(out_o[2], 2) && !$past(out_o[2]))
		else $error("trigger without pacer output fall");
	a_trig_one_cycle: assert property (pacer_trig_o |=> !pacer_trig_o)
		else $error("trigger wider than one cycle");
	a_pacer_min_gap: assert property (pacer_trig_o |-> gap >= 16'h00C7)
		else $error("pacer faster than source over four");
	a_ctrl_read_zero: assert property (rd_i && addr_i == 2'h3 |=>
		rdata_o == 8'h00) else $error("control offset read not zero");
	a_rdata_holds: assert property (!rd_i |=> $stable(rdata_o))
		else $error("read byte changed without a read");
	a_mode0_low: assert property (s_ctl0 and wdata_i[3:1] == 3'h0 |->
		##[1:2] !out_o[0]) else $error("mode 0 output not low");
	a_mode_other_high: assert property (s_ctl0 and wdata_i[3:1] != 3'h0
		|-> ##[1:2] out_o[0]) else $error("output not high on mode set");
	a_illegal_ignored: assert property (ctl_wr && wdata_i[7:6] == 2'h3
		&& clk0_src_ext_i && !clk0_ext_i && !$past(clk0_ext_i)
		|=> $stable(out_o[0])) else $error("illegal control byte acted");
endmodule
bind tcp_top tcp_monitor i_tcp_monitor (.mclk_i(mclk_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .clk0_ext_i(clk0_ext_i),
	.clk0_src_ext_i(clk0_src_ext_i), .gate_i(gate_i), .out_o(out_o),
	.pacer_trig_o(pacer_trig_o));

// ### testbench/tcp_host_model.sv
/* Host processor model: byte writes and reads of the counter ports.
   Assumes its tasks are called from one process at a time. */
`timescale 1ns/1ps
module tcp_host_model (
	input  wire logic       mclk_i,  // Clock
	input  wire logic [7:0] rdata_i, // Read byte
	output logic      [1:0] addr_o,  // Port offset
	output logic      [7:0] wdata_o, // Write byte
	output logic            wr_o,    // Write strobe
	output logic            rd_o     // Read strobe
);
	// ==================================================================
	// Bus cycles
	initial begin
		addr_o = 2'h0;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Idle lines flip so a stale byte can never pass for a fresh one
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge mclk_i);
		wr_o = 1'b0;
		wdata_o = ~d;
		addr_o = ~a;
	endtask
	// Read byte is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(negedge mclk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge mclk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		d = rdata_i;
	endtask
endmodule

// ### testbench/tb.sv
/* Self-checking bench for the triple counter pacer.
   Drives inputs on falling edges; host cycles come from the model. */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
	logic       mclk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       clk0_ext_i = 1'b0;
	logic       clk0_src_ext_i = 1'b1;
	logic [2:0] gate_i = 3'h7;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic [2:0] out_o;
	logic       pacer_trig;
	logic [7:0] b;
	int         n_mismatch = 0;
	int         num_checks = 0;
	int         cyc = 0;
	int         seed = 65670;
	int         n;
	int         n2;
	tcp_top i_tcp_top (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.clk0_ext_i(clk0_ext_i), .clk0_src_ext_i(clk0_src_ext_i),
		.gate_i(gate_i), .out_o(out_o), .pacer_trig_o(pacer_trig));
	tcp_host_model i_tcp_host_model (.mclk_i(mclk_i), .rdata_i(rdata),
		.addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	// ==================================================================
	// Clock and hang guard
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			report_and_stop;
		end
	end
	// ==================================================================
	// Helpers
	function automatic int rnd(int m);
		return $unsigned($random(seed)) % m;
	endfunction
	// Expected count after k ticks; decimal nibbles borrow as 9s
	function automatic logic [15:0] f_dec(logic [15:0] v, logic bcd, int k);
		for (int i = 0; i < k; i++) begin
			if (!bcd) v = v - 16'h0001;
			else if (v == 16'h0000) v = 16'h9999;
			else begin
				v = v - 16'h0001;
				for (int j = 0; j < 4; j++)
					if (v[4*j+:4] == 4'hF) v[4*j+:4] = 4'h9;
			end
		end
		return v;
	endfunction
	// External tick at 5 MHz, the fastest a counter must take
	task automatic tick0(int m);
		repeat (m) begin
			@(negedge mclk_i);
			clk0_ext_i = 1'b1;
			repeat (10) @(negedge mclk_i);
			clk0_ext_i = 1'b0;
			repeat (9) @(negedge mclk_i);
		end
	endtask
	task automatic t_fall(int idx, inout int g);
		while (out_o[idx] !== 1'b1 && g < 6000) begin
			@(negedge mclk_i);
			g++;
		end
		while (out_o[idx] !== 1'b0 && g < 6000) begin
			@(negedge mclk_i);
			g++;
		end
	endtask
	// First falls may still carry the old count, so measure the third
	task automatic t_gap(int idx, int e);
		int g;
		g = 0;
		t_fall(idx, g);
		t_fall(idx, g);
		g = 0;
		t_fall(idx, g);
		`CHK(g, e)
	endtask
	task automatic t_count(logic bcd, logic [1:0] acc, logic [15:0] v);
		int k;
		logic [15:0] e;
		k = 1 + rnd(5);
		e = (acc == 2'h1) ? {8'h00, v[7:0]}
		  : (acc == 2'h2) ? {v[15:8], 8'h00} : v;
		i_tcp_host_model.wr(2'h3, {2'h0, acc, 3'h0, bcd});
		if (acc != 2'h2) i_tcp_host_model.wr(2'h0, v[7:0]);
		if (acc != 2'h1) i_tcp_host_model.wr(2'h0, v[15:8]);
		tick0(1);
		gate_i[0] = 1'b0;
		tick0(2);
		gate_i[0] = 1'b1;
		tick0(k);
		e = f_dec(e, bcd, k);
		i_tcp_host_model.wr(2'h3, 8'h00);
		if (acc != 2'h2) begin
			i_tcp_host_model.rd(2'h0, b);
			`CHK(b, e[7:0])
		end
		i_tcp_host_model.wr(2'h3, 8'hF4);
		if (acc != 2'h1) begin
			i_tcp_host_model.rd(2'h0, b);
			`CHK(b, e[15:8])
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ==================================================================
	// Main sequence
	initial begin
		repeat (2) @(negedge mclk_i);
		rst_i = 1'b0;
		`CHK(out_o, 3'h7)
		`CHK(rdata, 8'h00)
		i_tcp_host_model.rd(2'h3, b);
		`CHK(b, 8'h00)
		for (int c = 0; c < 8; c++) begin
			i_tcp_host_model.wr(2'h3, {4'h3, 3'(c), 1'b0});
			repeat (2) @(negedge mclk_i);
			`CHK(out_o[0], c != 0)
		end
		t_count(1'b0, 2'h3, 16'h0000);
		t_count(1'b1, 2'h3, 16'h0000);
		t_count(1'b1, 2'h3, {4'(rnd(10)), 4'(rnd(10)),
		                     4'(rnd(10)), 4'(rnd(10))});
		t_count(1'b0, 2'h1, 16'(rnd(65536)));
		t_count(1'b0, 2'h2, 16'(rnd(65536)));
		t_count(1'b0, 2'h3, 16'(rnd(65536)));
		clk0_src_ext_i = 1'b0;
		// Mode 2, mode 2 through code 110, then the square wave mode
		for (int m = 0; m < 3; m++) begin
			n = 2 + rnd(5);
			i_tcp_host_model.wr(2'h3,
				(m == 0) ? 8'h34 : (m == 1) ? 8'h3C : 8'h36);
			i_tcp_host_model.wr(2'h0, 8'(n));
			i_tcp_host_model.wr(2'h0, 8'h00);
			// Square wave trims an odd count to the even one below
			t_gap(0, tcp_pkg::PACER_DIV * ((m == 2) ? n - n % 2 : n));
		end
		for (int p = 0; p < 3; p++) begin
			n = 2 + ((p == 0) ? 0 : rnd(4));
			n2 = 2 + ((p == 0) ? 0 : rnd(4));
			i_tcp_host_model.wr(2'h3, 8'h74);
			i_tcp_host_model.wr(2'h1, 8'(n));
			i_tcp_host_model.wr(2'h1, 8'h00);
			i_tcp_host_model.wr(2'h3, 8'hB4);
			i_tcp_host_model.wr(2'h2, 8'(n2));
			i_tcp_host_model.wr(2'h2, 8'h00);
			t_gap(2, tcp_pkg::PACER_DIV * n * n2);
			// Trigger is registered, so it shows one cycle after the fall
			`CHK(pacer_trig, 1'b0)
			@(negedge mclk_i);
			`CHK(pacer_trig, 1'b1)
		end
		gate_i[2:1] = 2'h0;
		repeat (300) @(negedge mclk_i);
		`CHK(out_o[2:1], 2'h3)
		report_and_stop;
	end
endmodule
